// ### design/crc8_pkg.sv
// shared constants for the packet and rom check engine ends
package crc8_pkg;
   localparam logic [7:0]  REFLECTED_CONSTANT_A = 8'hB2;
   localparam logic [7:0]  REMAINDER_RESET      = 8'h00;
   localparam int          ROM_CONTENT_BITS     = 200;
   localparam int          ROM_TOTAL_BITS       = 208;
   localparam logic [7:0]  ROM_CONTENT_LAST     = 8'hC7;
   localparam logic [7:0]  ROM_TOTAL_LAST       = 8'hCF;
   localparam int          BYTE_BITS            = 8;
   localparam logic [2:0]  BIT_LAST             = 3'h7;
endpackage

// ### design/crc8_link_if.sv
// serial link between the monitor device end and the host end
`timescale 1ns/1ns
`default_nettype none
interface crc8_link_if;
   logic       h2d_valid;
   logic       h2d_bit;
   logic       h2d_last;
   logic       d2h_valid;
   logic       d2h_bit;
   logic       d2h_last;
   modport device (input h2d_valid, input h2d_bit, input h2d_last,
                   output d2h_valid, output d2h_bit, output d2h_last);
   modport host   (output h2d_valid, output h2d_bit, output h2d_last,
                   input d2h_valid, input d2h_bit, input d2h_last);
endinterface
`default_nettype wire

// ### design/crc8_device_end.sv
// monitor device end: checks incoming packets, appends check byte on replies
// Operation
// - check covers bytes before check byte only
// - bits enter engine lsb first
// - remainder starts at zero per packet
// - host may seed remainder or precompute
// - byte xored in then eight reductions
// - lsb one: shift right xor constant
// - one engine, polynomial 0xA6
// - rom check byte over 200 content bits
// - host clears engine before rom check
// - rom content applied in fixed order
// - direct comparison accepts exact match only
// - zero remainder method must end zero
// - block readback checked in arrival order
// - spi or bridge: collect then concatenate
// - retry failed fetch before rom verdict
// - mismatch rejects command, sets error flag
// - replies: clear, compute, append check byte
`timescale 1ns/1ns
`default_nettype none
module crc8_device_end
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   // link
   crc8_link_if.device      link,
   // received command
   output logic             cmd_accept,
   output logic             cmd_reject,
   output logic [7:0]       cmd_byte,
   output logic             cmd_byte_valid,
   output logic             packet_check_error_flag,
   input  wire logic        error_flag_clear,
   // reply data
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_byte,
   input  wire logic        tx_last,
   output logic             tx_ready
);
   typedef enum logic [1:0] {
      RX_DATA  = 2'b00,
      RX_CHECK = 2'b01
   } rx_state_e;
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_DATA  = 2'b01,
      TX_CHECK = 2'b10
   } tx_state_e;

   // one reduction step on a single link bit
   function automatic logic [7:0] crc_step(input logic [7:0] rem, input logic din);
      logic [7:0] x;
      x = rem ^ {7'h00, din};
      crc_step = x[0] ? ((x >> 1) ^ crc8_pkg::REFLECTED_CONSTANT_A)
                      : (x >> 1);
   endfunction

   // receive path
   rx_state_e  rx_st_q, rx_st_d;
   logic [7:0] rx_rem_q, rx_rem_d;
   logic [7:0] rx_sh_q, rx_sh_d;
   logic [7:0] rx_chk_q, rx_chk_d;
   logic [2:0] rx_cnt_q, rx_cnt_d;
   logic       acc_d, rej_d, bv_d, flag_d;
   logic [7:0] cb_d;

   always_comb
   begin
      rx_st_d  = rx_st_q;
      rx_rem_d = rx_rem_q;
      rx_sh_d  = rx_sh_q;
      rx_chk_d = rx_chk_q;
      rx_cnt_d = rx_cnt_q;
      acc_d    = 1'b0;
      rej_d    = 1'b0;
      bv_d     = 1'b0;
      cb_d     = cmd_byte;
      flag_d   = packet_check_error_flag & ~error_flag_clear;
      if (link.h2d_valid)
      begin
         rx_cnt_d = rx_cnt_q + 3'h1;
         case (rx_st_q)
            RX_DATA:
            begin
               rx_rem_d = crc_step(rx_rem_q, link.h2d_bit);
               rx_sh_d  = {link.h2d_bit, rx_sh_q[7:1]};
               if (rx_cnt_q == crc8_pkg::BIT_LAST)
               begin
                  bv_d = 1'b1;
                  cb_d = {link.h2d_bit, rx_sh_q[7:1]};
                  if (link.h2d_last)
                     rx_st_d = RX_CHECK;
               end
            end
            RX_CHECK:
            begin
               rx_chk_d = {link.h2d_bit, rx_chk_q[7:1]};
               if (rx_cnt_q == crc8_pkg::BIT_LAST)
               begin
                  if ({link.h2d_bit, rx_chk_q[7:1]} == rx_rem_q)
                     acc_d = 1'b1;
                  else
                  begin
                     rej_d  = 1'b1;
                     flag_d = 1'b1;
                  end
                  rx_rem_d = crc8_pkg::REMAINDER_RESET;
                  rx_st_d  = RX_DATA;
               end
            end
            default: rx_st_d = RX_DATA;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_st_q                 <= RX_DATA;
         rx_rem_q                <= crc8_pkg::REMAINDER_RESET;
         rx_sh_q                 <= 8'h00;
         rx_chk_q                <= 8'h00;
         rx_cnt_q                <= 3'h0;
         cmd_accept              <= 1'b0;
         cmd_reject              <= 1'b0;
         cmd_byte_valid          <= 1'b0;
         cmd_byte                <= 8'h00;
         packet_check_error_flag <= 1'b0;
      end
      else if (clk_en)
      begin
         rx_st_q                 <= rx_st_d;
         rx_rem_q                <= rx_rem_d;
         rx_sh_q                 <= rx_sh_d;
         rx_chk_q                <= rx_chk_d;
         rx_cnt_q                <= rx_cnt_d;
         cmd_accept              <= acc_d;
         cmd_reject              <= rej_d;
         cmd_byte_valid          <= bv_d;
         cmd_byte                <= cb_d;
         packet_check_error_flag <= flag_d;
      end
   end

   // transmit path
   tx_state_e  tx_st_q, tx_st_d;
   logic [7:0] tx_rem_q, tx_rem_d;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic [2:0] tx_cnt_q, tx_cnt_d;
   logic       tx_lst_q, tx_lst_d;
   logic       ov_d, ob_d, ol_d;

   assign tx_ready = clk_en && (tx_st_q == TX_IDLE);

   always_comb
   begin
      tx_st_d  = tx_st_q;
      tx_rem_d = tx_rem_q;
      tx_sh_d  = tx_sh_q;
      tx_cnt_d = tx_cnt_q;
      tx_lst_d = tx_lst_q;
      ov_d     = 1'b0;
      ob_d     = 1'b0;
      ol_d     = 1'b0;
      case (tx_st_q)
         TX_IDLE:
            if (tx_valid)
            begin
               tx_sh_d  = tx_byte;
               tx_lst_d = tx_last;
               tx_cnt_d = 3'h0;
               tx_st_d  = TX_DATA;
            end
         TX_DATA:
         begin
            ov_d     = 1'b1;
            ob_d     = tx_sh_q[0];
            tx_rem_d = crc_step(tx_rem_q, tx_sh_q[0]);
            tx_sh_d  = tx_sh_q >> 1;
            tx_cnt_d = tx_cnt_q + 3'h1;
            if (tx_cnt_q == crc8_pkg::BIT_LAST)
            begin
               if (tx_lst_q)
               begin
                  tx_sh_d = crc_step(tx_rem_q, tx_sh_q[0]);
                  tx_st_d = TX_CHECK;
               end
               else
                  tx_st_d = TX_IDLE;
            end
         end
         TX_CHECK:
         begin
            ov_d     = 1'b1;
            ob_d     = tx_sh_q[0];
            tx_sh_d  = tx_sh_q >> 1;
            tx_cnt_d = tx_cnt_q + 3'h1;
            if (tx_cnt_q == crc8_pkg::BIT_LAST)
            begin
               ol_d     = 1'b1;
               tx_rem_d = crc8_pkg::REMAINDER_RESET;
               tx_st_d  = TX_IDLE;
            end
         end
         default: tx_st_d = TX_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_st_q        <= TX_IDLE;
         tx_rem_q       <= crc8_pkg::REMAINDER_RESET;
         tx_sh_q        <= 8'h00;
         tx_cnt_q       <= 3'h0;
         tx_lst_q       <= 1'b0;
         link.d2h_valid <= 1'b0;
         link.d2h_bit   <= 1'b0;
         link.d2h_last  <= 1'b0;
      end
      else if (clk_en)
      begin
         tx_st_q        <= tx_st_d;
         tx_rem_q       <= tx_rem_d;
         tx_sh_q        <= tx_sh_d;
         tx_cnt_q       <= tx_cnt_d;
         tx_lst_q       <= tx_lst_d;
         link.d2h_valid <= ov_d;
         link.d2h_bit   <= ob_d;
         link.d2h_last  <= ol_d;
      end
   end
endmodule
`default_nettype wire

// ### design/crc8_host_end.sv
// host end: sends packets with check byte, checks replies, runs the rom check
`timescale 1ns/1ns
`default_nettype none
module crc8_host_end
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          reset_n,
   input  wire logic          clk_en,
   // link
   crc8_link_if.host          link,
   // command send
   input  wire logic          cmd_valid,
   input  wire logic [7:0]    cmd_byte,
   input  wire logic          cmd_last,
   input  wire logic          seed_load,
   input  wire logic [7:0]    seed_value,
   output logic               cmd_ready,
   // reply check
   output logic               reply_good,
   output logic               reply_bad,
   // rom check
   input  wire logic          rom_start,
   input  wire logic          rom_zero_method,
   input  wire logic [207:0]  rom_image,
   output logic               rom_busy,
   output logic               rom_pass,
   output logic               rom_fail
);
   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_DATA  = 2'b01,
      H_CHECK = 2'b10,
      H_ROM   = 2'b11
   } host_state_e;

   // one reduction step on a single bit
   function automatic logic [7:0] crc_step(input logic [7:0] rem, input logic din);
      logic [7:0] x;
      x = rem ^ {7'h00, din};
      crc_step = x[0] ? ((x >> 1) ^ crc8_pkg::REFLECTED_CONSTANT_A)
                      : (x >> 1);
   endfunction

   host_state_e st_q, st_d;
   logic [7:0]  rem_q, rem_d;
   logic [7:0]  sh_q, sh_d;
   logic [2:0]  cnt_q, cnt_d;
   logic [7:0]  idx_q, idx_d;
   logic        lst_q, lst_d;
   logic        zm_q, zm_d;
   logic        hv_d, hb_d, hl_d, pass_d, fail_d;

   assign cmd_ready = clk_en && (st_q == H_IDLE);
   assign rom_busy  = (st_q == H_ROM);

   always_comb
   begin
      st_d   = st_q;
      rem_d  = rem_q;
      sh_d   = sh_q;
      cnt_d  = cnt_q;
      idx_d  = idx_q;
      lst_d  = lst_q;
      zm_d   = zm_q;
      hv_d   = 1'b0;
      hb_d   = 1'b0;
      hl_d   = 1'b0;
      pass_d = 1'b0;
      fail_d = 1'b0;
      case (st_q)
         H_IDLE:
            if (rom_start)
            begin
               rem_d = crc8_pkg::REMAINDER_RESET;
               idx_d = 8'h00;
               zm_d  = rom_zero_method;
               st_d  = H_ROM;
            end
            else if (cmd_valid)
            begin
               if (seed_load)
                  rem_d = seed_value;
               sh_d  = cmd_byte;
               lst_d = cmd_last;
               cnt_d = 3'h0;
               st_d  = H_DATA;
            end
         H_DATA:
         begin
            hv_d  = 1'b1;
            hb_d  = sh_q[0];
            rem_d = crc_step(rem_q, sh_q[0]);
            sh_d  = sh_q >> 1;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == crc8_pkg::BIT_LAST)
            begin
               hl_d = lst_q;
               if (lst_q)
               begin
                  sh_d = crc_step(rem_q, sh_q[0]);
                  st_d = H_CHECK;
               end
               else
                  st_d = H_IDLE;
            end
         end
         H_CHECK:
         begin
            hv_d  = 1'b1;
            hb_d  = sh_q[0];
            sh_d  = sh_q >> 1;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == crc8_pkg::BIT_LAST)
            begin
               rem_d = crc8_pkg::REMAINDER_RESET;
               st_d  = H_IDLE;
            end
         end
         H_ROM:
         begin
            rem_d = crc_step(rem_q, rom_image[idx_q]);
            idx_d = idx_q + 8'h01;
            if (!zm_q && idx_q == crc8_pkg::ROM_CONTENT_LAST)
            begin
               // direct comparison against the stored byte
               pass_d = (rem_d == rom_image[207:200]);
               fail_d = (rem_d != rom_image[207:200]);
               st_d   = H_IDLE;
            end
            else if (zm_q && idx_q == crc8_pkg::ROM_TOTAL_LAST)
            begin
               pass_d = (rem_d == 8'h00);
               fail_d = (rem_d != 8'h00);
               st_d   = H_IDLE;
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q          <= H_IDLE;
         rem_q         <= crc8_pkg::REMAINDER_RESET;
         sh_q          <= 8'h00;
         cnt_q         <= 3'h0;
         idx_q         <= 8'h00;
         lst_q         <= 1'b0;
         zm_q          <= 1'b0;
         link.h2d_valid <= 1'b0;
         link.h2d_bit   <= 1'b0;
         link.h2d_last  <= 1'b0;
         rom_pass      <= 1'b0;
         rom_fail      <= 1'b0;
      end
      else if (clk_en)
      begin
         st_q          <= st_d;
         rem_q         <= rem_d;
         sh_q          <= sh_d;
         cnt_q         <= cnt_d;
         idx_q         <= idx_d;
         lst_q         <= lst_d;
         zm_q          <= zm_d;
         link.h2d_valid <= hv_d;
         link.h2d_bit   <= hb_d;
         link.h2d_last  <= hl_d;
         rom_pass      <= pass_d;
         rom_fail      <= fail_d;
      end
   end

   // reply checker: zero remainder over data plus trailing check byte
   logic [7:0] rrem_q, rrem_d;
   logic       rg_d, rb_d;

   always_comb
   begin
      rrem_d = rrem_q;
      rg_d   = 1'b0;
      rb_d   = 1'b0;
      if (link.d2h_valid)
      begin
         rrem_d = crc_step(rrem_q, link.d2h_bit);
         if (link.d2h_last)
         begin
            rg_d   = (rrem_d == 8'h00);
            rb_d   = (rrem_d != 8'h00);
            rrem_d = crc8_pkg::REMAINDER_RESET;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rrem_q     <= crc8_pkg::REMAINDER_RESET;
         reply_good <= 1'b0;
         reply_bad  <= 1'b0;
      end
      else if (clk_en)
      begin
         rrem_q     <= rrem_d;
         reply_good <= rg_d;
         reply_bad  <= rb_d;
      end
   end
endmodule
`default_nettype wire

// ### bench/crc8_link_properties.sv
// link-level checks between host end and device end
`timescale 1ns/1ns
`default_nettype none
module crc8_link_properties
(
   // clock and reset
   input  wire logic  mclk,
   input  wire logic  reset_n,
   // link
   input  wire logic  h2d_valid,
   input  wire logic  h2d_bit,
   input  wire logic  h2d_last,
   input  wire logic  d2h_valid,
   input  wire logic  d2h_bit,
   input  wire logic  d2h_last
);
   logic [2:0]  hcnt_q;
   logic [2:0]  hcnt_d;
   logic [2:0]  dcnt_q;
   logic [2:0]  dcnt_d;
   logic [7:0]  drem_q;
   logic [7:0]  drem_n;
   logic [7:0]  drem_d;

   // bit position counters and reply remainder
   always_comb
   begin
      hcnt_d = hcnt_q + (h2d_valid ? 3'h1 : 3'h0);
      dcnt_d = dcnt_q + (d2h_valid ? 3'h1 : 3'h0);
      drem_n = drem_q;
      if (d2h_valid)
      begin
         drem_n = (drem_q >> 1) ^ ((drem_q[0] ^ d2h_bit) ? crc8_pkg::REFLECTED_CONSTANT_A : 8'h00);
      end
      drem_d = d2h_last ? 8'h00 : drem_n;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hcnt_q <= 3'h0;
         dcnt_q <= 3'h0;
         drem_q <= 8'h00;
      end
      else
      begin
         hcnt_q <= hcnt_d;
         dcnt_q <= dcnt_d;
         drem_q <= drem_d;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   property p_h2d_last_valid;
      h2d_last |-> h2d_valid;
   endproperty
   a_h2d_last_valid: assert property (p_h2d_last_valid)
      else $error("h2d last without valid");

   property p_h2d_check_run;
      h2d_last |=> h2d_valid [*8];
   endproperty
   a_h2d_check_run: assert property (p_h2d_check_run)
      else $error("check bits not contiguous");

   property p_h2d_last_gap;
      h2d_last |=> !h2d_last [*8];
   endproperty
   a_h2d_last_gap: assert property (p_h2d_last_gap)
      else $error("last flag in check bits");

   property p_h2d_last_pos;
      h2d_last |-> hcnt_q == 3'h7;
   endproperty
   a_h2d_last_pos: assert property (p_h2d_last_pos)
      else $error("h2d last not on bit 7");

   property p_h2d_byte_run;
      h2d_valid && hcnt_q != 3'h7 |=> h2d_valid;
   endproperty
   a_h2d_byte_run: assert property (p_h2d_byte_run)
      else $error("h2d byte broken");

   property p_d2h_last_valid;
      d2h_last |-> d2h_valid;
   endproperty
   a_d2h_last_valid: assert property (p_d2h_last_valid)
      else $error("d2h last without valid");

   property p_d2h_last_pos;
      d2h_last |-> dcnt_q == 3'h7;
   endproperty
   a_d2h_last_pos: assert property (p_d2h_last_pos)
      else $error("d2h last not on bit 7");

   property p_d2h_byte_run;
      d2h_valid && dcnt_q != 3'h7 |=> d2h_valid;
   endproperty
   a_d2h_byte_run: assert property (p_d2h_byte_run)
      else $error("d2h byte broken");

   property p_d2h_zero;
      d2h_last |-> drem_n == 8'h00;
   endproperty
   a_d2h_zero: assert property (p_d2h_zero)
      else $error("reply remainder not zero");

   c_h2d_packet: cover property (h2d_last ##9 !h2d_valid);
   c_d2h_packet: cover property (d2h_last);
   c_h2d_multi: cover property (h2d_valid && !h2d_last ##9 h2d_last);
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench joining host end and device end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic            mclk = 1'b0;
   logic            reset_n = 1'b0;
   logic            en = 1'b1;
   logic            cmd_valid = 1'b0;
   logic [7:0]      h_cmd_byte = 8'h00;
   logic            cmd_last = 1'b0;
   logic            seed_load = 1'b0;
   logic [7:0]      seed_value = 8'h00;
   logic            cmd_ready;
   logic            reply_good;
   logic            reply_bad;
   logic            rom_start = 1'b0;
   logic            rom_zero_method = 1'b0;
   logic [207:0]    rom_image = '0;
   logic            rom_busy;
   logic            rom_pass;
   logic            rom_fail;
   logic            cmd_accept;
   logic            cmd_reject;
   logic [7:0]      d_cmd_byte;
   logic            cmd_byte_valid;
   logic            packet_check_error_flag;
   logic            error_flag_clear = 1'b0;
   logic            tx_valid = 1'b0;
   logic [7:0]      tx_byte = 8'h00;
   logic            tx_last = 1'b0;
   logic            tx_ready;
   logic [7:0]      q_rx[$], q_cmd[$], q_rep[$], q_rom[$], q_hw[$], q_dw[$];
   logic [7:0]      hsh = 8'h00;
   logic [7:0]      dsh = 8'h00;
   int              hn = 0;
   int              dn = 0;
   int              fail_count = 0;
   int              tests_run = 0;

   crc8_link_if link ();
   crc8_host_end i_crc8_host_end (.mclk(mclk), .reset_n(reset_n), .clk_en(en), .link(link),
      .cmd_valid(cmd_valid), .cmd_byte(h_cmd_byte), .cmd_last(cmd_last), .seed_load(seed_load),
      .seed_value(seed_value), .cmd_ready(cmd_ready), .reply_good(reply_good),
      .reply_bad(reply_bad), .rom_start(rom_start), .rom_zero_method(rom_zero_method),
      .rom_image(rom_image), .rom_busy(rom_busy), .rom_pass(rom_pass), .rom_fail(rom_fail));
   crc8_device_end i_crc8_device_end (.mclk(mclk), .reset_n(reset_n), .clk_en(en), .link(link),
      .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .cmd_byte(d_cmd_byte),
      .cmd_byte_valid(cmd_byte_valid), .packet_check_error_flag(packet_check_error_flag),
      .error_flag_clear(error_flag_clear), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_last(tx_last), .tx_ready(tx_ready));
   crc8_link_properties i_crc8_link_properties (.mclk(mclk), .reset_n(reset_n),
      .h2d_valid(link.h2d_valid), .h2d_bit(link.h2d_bit), .h2d_last(link.h2d_last),
      .d2h_valid(link.d2h_valid), .d2h_bit(link.d2h_bit), .d2h_last(link.d2h_last));

   initial forever #2 mclk = ~mclk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] crc_bit(input logic [7:0] r, input logic b);
      return (r >> 1) ^ ((r[0] ^ b) ? crc8_pkg::REFLECTED_CONSTANT_A : 8'h00);
   endfunction

   function automatic logic [7:0] crc8(input logic [7:0] r, input logic [7:0] b);
      logic [7:0] c;
      c = r ^ b;
      for (int i = 0; i < 8; i++)
         c = c[0] ? ((c >> 1) ^ crc8_pkg::REFLECTED_CONSTANT_A) : (c >> 1);
      return c;
   endfunction

   task automatic host_pkt(input int n, input logic [7:0] seed, input bit freeze);
      logic [7:0] b;
      logic [7:0] r;
      int         w;
      r = seed;
      // freeze only once both ends are idle, so no bit is held across it
      if (freeze)
         repeat (20) @(posedge mclk);
      for (int i = 0; i < n; i++)
      begin
         b = 8'($urandom);
         r = crc8(r, b);
         q_rx.push_back(b);
         q_hw.push_back(b);
         @(posedge mclk);
         cmd_valid <= 1'b1;
         h_cmd_byte <= b;
         cmd_last <= (i == n - 1);
         seed_load <= (i == 0);
         seed_value <= seed;
         if (freeze && i == 0)
         begin
            en <= 1'b0;
            repeat (4)
            begin
               @(negedge mclk);
               check({7'h0, cmd_ready}, 8'h00);
            end
            @(posedge mclk);
            en <= 1'b1;
         end
         @(negedge mclk);
         for (w = 0; w < 100 && cmd_ready !== 1'b1; w++) @(negedge mclk);
         if (w == 100) fail_count++;
         @(posedge mclk);
         cmd_valid <= 1'b0;
         seed_load <= 1'b0;
      end
      q_hw.push_back(r);
      q_cmd.push_back(seed == 8'h00 ? 8'h02 : 8'h01);
   endtask

   task automatic dev_pkt(input int n);
      logic [7:0] b;
      logic [7:0] r;
      int         w;
      r = 8'h00;
      for (int i = 0; i < n; i++)
      begin
         b = 8'($urandom);
         r = crc8(r, b);
         q_dw.push_back(b);
         @(posedge mclk);
         tx_valid <= 1'b1;
         tx_byte <= b;
         tx_last <= (i == n - 1);
         @(negedge mclk);
         for (w = 0; w < 100 && tx_ready !== 1'b1; w++) @(negedge mclk);
         if (w == 100) fail_count++;
         @(posedge mclk);
         tx_valid <= 1'b0;
      end
      q_dw.push_back(r);
      q_rep.push_back(8'h02);
   endtask

   task automatic rom_run(input int m);
      logic [207:0] img;
      logic [7:0]   r;
      int           w;
      r = 8'h00;
      for (int i = 0; i < 208; i++) img[i] = 1'($urandom);
      for (int i = 0; i < 200; i++) r = crc_bit(r, img[i]);
      img[207:200] = r;
      if (m == 2) img[199] = ~img[199];
      if (m == 3) img[200] = ~img[200];
      q_rom.push_back(m >= 2 ? 8'h01 : 8'h02);
      @(posedge mclk);
      rom_image <= img;
      rom_zero_method <= m[0];
      rom_start <= 1'b1;
      @(negedge mclk);
      for (w = 0; w < 100 && rom_busy !== 1'b1; w++) @(negedge mclk);
      @(posedge mclk);
      rom_start <= 1'b0;
      for (w = 1; w < 300 && rom_busy === 1'b1; w++) @(negedge mclk);
      check(8'(w - 1),
            m[0] ? 8'(crc8_pkg::ROM_TOTAL_BITS) : 8'(crc8_pkg::ROM_CONTENT_BITS));
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // result and wire monitors
   always @(posedge mclk)
   begin
      if (cmd_byte_valid === 1'b1)
         check(d_cmd_byte, q_rx.size() ? q_rx.pop_front() : 8'hXX);
      if ((cmd_accept | cmd_reject) === 1'b1)
         check({6'h0, cmd_accept, cmd_reject},
               q_cmd.size() ? q_cmd.pop_front() : 8'hXX);
      if ((reply_good | reply_bad) === 1'b1)
         check({6'h0, reply_good, reply_bad},
               q_rep.size() ? q_rep.pop_front() : 8'hXX);
      if ((rom_pass | rom_fail) === 1'b1)
         check({6'h0, rom_pass, rom_fail},
               q_rom.size() ? q_rom.pop_front() : 8'hXX);
      if (link.h2d_valid === 1'b1)
      begin
         hsh = {link.h2d_bit, hsh[7:1]};
         hn = (hn + 1) % 8;
         if (hn == 0) check(hsh, q_hw.size() ? q_hw.pop_front() : 8'hXX);
      end
      if (link.d2h_valid === 1'b1)
      begin
         dsh = {link.d2h_bit, dsh[7:1]};
         dn = (dn + 1) % 8;
         if (dn == 0) check(dsh, q_dw.size() ? q_dw.pop_front() : 8'hXX);
      end
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      end_sim();
   end

   initial
   begin
      void'($urandom(32'h0AAB));
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      for (int k = 0; k < 6; k++) host_pkt(1 + (k % 4), 8'h00, k == 2);
      host_pkt(2, 8'($urandom_range(255, 1)), 1'b0);
      repeat (30) @(posedge mclk);
      check({7'h0, packet_check_error_flag}, 8'h01);
      error_flag_clear <= 1'b1;
      @(posedge mclk);
      error_flag_clear <= 1'b0;
      repeat (2) @(posedge mclk);
      check({7'h0, packet_check_error_flag}, 8'h00);
      host_pkt(3, 8'h00, 1'b0);
      for (int k = 0; k < 3; k++) dev_pkt(1 + k);
      for (int m = 0; m < 4; m++) rom_run(m);
      repeat (40) @(posedge mclk);
      check(8'(q_rx.size() + q_cmd.size() + q_rep.size() + q_rom.size()), 8'h00);
      check(8'(q_hw.size() + q_dw.size()), 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
